// ==== dv/tx_header_quadlet1_regs_tb.sv ====
// Self-checking testbench for the transmit header quadlet 1 register bank
`timescale 1ns/100ps
module tx_header_quadlet1_regs_tb
    import txh1_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus signals
    // ------------------------------------------------------------
    logic sys_clk, rst, clk_en, cyc, stb, we, ack, phy_v, done, source_packet_header_flag, hreq, hval;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, st, hq;
    logic [7:0] opt, blocks;
    logic [4:0] node;
    logic [2:0] pbuf, quadlet_padding_count, hbuf;
    logic [1:0] fn;
    int fails, n_checks, cycles;

    tx_header_quadlet1_regs u_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .stream_type(st),
        .new_cell_header_option(opt), .phy_reg0_valid(phy_v), .phy_node_id(node),
        .tx_pkt_done(done), .tx_pkt_buf(pbuf), .tx_pkt_blocks(blocks), .tx_pkt_fn(fn),
        .tx_pkt_qpc(quadlet_padding_count), .tx_pkt_sph(source_packet_header_flag), .hdr_req(hreq), .hdr_buf(hbuf),
        .hdr_quadlet(hq), .hdr_valid(hval));

    always #2.5 sys_clk = ~sys_clk;

    // Ceiling well above the roughly 160 cycles the scenarios need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t exp %h got %h", $time, exp, got);
        end
    endtask

    // Master holds the request until ack is sampled, then releases it
    task automatic wb(input logic w, input int b, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        if (b > 7) begin
            adr <= 12'h25C + 12'(4 * (b - 8));
        end else begin
            adr <= BUF_OFFSET[b];
        end
        sel <= s;
        wdat <= d;
        // No latency assumed; only the bench ceiling ends this wait
        do begin
            @(posedge sys_clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd_chk(input int b, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, b, 4'hF, 32'h0, q);
        chk(exp, q);
    endtask

    task automatic wr(input int b, input logic [3:0] s, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, b, s, d, q);
    endtask

    task automatic hdr_chk(input logic [2:0] b, input logic [31:0] exp);
        logic got;
        got = 0;
        @(posedge sys_clk);
        hreq <= 1'b1;
        hbuf <= b;
        @(posedge sys_clk);
        hreq <= 1'b0;
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge sys_clk);
            if (hval === 1'b1) got = 1;
        end
        chk(32'h1, {31'h0, got});
        chk(exp, hq);
    endtask

    // Holds the packet pulse for n back-to-back cycles
    task automatic pkt(input logic [2:0] b, input logic [7:0] k, input logic [1:0] f,
                       input logic [2:0] p, input logic s, input int n);
        @(posedge sys_clk);
        done <= 1'b1;
        pbuf <= b;
        blocks <= k;
        fn <= f;
        quadlet_padding_count <= p;
        source_packet_header_flag <= s;
        repeat (n) @(posedge sys_clk);
        done <= 1'b0;
    endtask

    function automatic logic [31:0] vid(input logic [4:0] s, input logic [7:0] d,
        input logic [1:0] f, input logic [2:0] p, input logic h, input logic [7:0] c);
        return {3'h0, s, d, f, p, h, 2'h0, c};
    endfunction

    function automatic logic [7:0] exp_dbs(input int t);
        case (t)
            4, 5: return 8'h09;
            6: return 8'h06;
            7, 9: return 8'h78;
            default: return 8'hF0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(0, 32'h0006_C400);
        rd_chk(5, 32'h0078_0000);
        rd_chk(4, 32'h0000_0000);
    endtask

    task automatic t_async();
        wr(4, 4'hF, 32'h1234_5678);
        wr(4, 4'h3, 32'hAAAA_BBBB);
        rd_chk(4, 32'h1234_BBBB);
        wr(4, 4'hC, 32'hFEDC_0000);
        rd_chk(4, 32'hFEDC_BBBB);
        hdr_chk(3'h4, 32'hFEDC_BBBB);
    endtask

    task automatic t_video_wr();
        wr(0, 4'hF, 32'hFFFF_FFFF);
        rd_chk(0, 32'h0006_C400);
        wr(0, 4'hF, 32'h0000_0000);
        rd_chk(0, 32'h0006_C000);
        hdr_chk(3'h0, 32'h0006_C000);
    endtask

    task automatic t_source_id();
        @(posedge sys_clk);
        clk_en <= 1'b0;
        phy_v <= 1'b1;
        node <= 5'h0A;
        @(posedge sys_clk);
        clk_en <= 1'b1;
        phy_v <= 1'b0;
        rd_chk(0, vid(5'h00, 8'h06, 2'h3, 3'h0, 1'b0, 8'h00));
        @(posedge sys_clk);
        phy_v <= 1'b1;
        node <= 5'h15;
        @(posedge sys_clk);
        phy_v <= 1'b0;
        rd_chk(0, vid(5'h15, 8'h06, 2'h3, 3'h0, 1'b0, 8'h00));
    endtask

    task automatic t_pkt();
        @(posedge sys_clk);
        opt <= 8'h01;
        pkt(3'h0, 8'hF0, 2'h2, 3'h5, 1'b1, 2);
        rd_chk(0, vid(5'h15, 8'h06, 2'h2, 3'h5, 1'b1, 8'hE0));
        wr(0, 4'h2, 32'h0000_0000);
        rd_chk(0, vid(5'h15, 8'h06, 2'h2, 3'h5, 1'b1, 8'hE0));
        pkt(3'h0, 8'h21, 2'h1, 3'h0, 1'b0, 1);
        rd_chk(0, vid(5'h15, 8'h06, 2'h1, 3'h0, 1'b0, 8'h01));
        pkt(3'h0, 8'h01, 2'h0, 3'h7, 1'b0, 1);
        rd_chk(0, vid(5'h15, 8'h06, 2'h0, 3'h7, 1'b0, 8'h02));
        pkt(3'h4, 8'h05, 2'h1, 3'h1, 1'b1, 1);
        rd_chk(4, 32'hFEDC_BBBB);
    endtask

    task automatic t_dbs();
        for (int t = 4; t <= 10; t++) begin
            @(posedge sys_clk);
            st[7:4] <= 4'(t);
            rd_chk(1, vid(5'h15, exp_dbs(t), 2'h0, 3'h0, 1'b0, 8'h00));
        end
        hdr_chk(3'h1, vid(5'h15, 8'hF0, 2'h0, 3'h0, 1'b0, 8'h00));
    endtask

    task automatic t_unmapped();
        wr(8, 4'hF, 32'hDEAD_BEEF);
        rd_chk(8, 32'h0000_0000);
        rd_chk(9, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 0;
        rst = 1;
        clk_en = 1;
        {cyc, stb, we, phy_v, done, source_packet_header_flag, hreq} = '0;
        adr = '0;
        sel = '0;
        wdat = '0;
        st = 32'h0071_0006;
        opt = '0;
        blocks = '0;
        node = '0;
        pbuf = '0;
        quadlet_padding_count = '0;
        hbuf = '0;
        fn = '0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_async();
        t_video_wr();
        t_source_id();
        t_pkt();
        t_dbs();
        t_unmapped();
        tally_and_finish();
    end
endmodule

// ==== src/tx_header_quadlet1_regs.sv ====
// Transmit header quadlet 1 register bank for eight buffers, Wishbone slave
// Functional notes
// - A buffer with stream type 1 shows the asynchronous layout; buffer 4 defaults to it.
// - A buffer with stream type 4 to 10 shows the video layout; buffer 0 defaults to it.
// - Async bits 31:16 hold a writable destination node id, reset zero, sent in the header.
// - Async bits 15:0 hold the writable upper destination offset, sent in the header.
// - Video bits 31:29 and 9:8 ignore writes and read as zero.
// - Video bits 28:24 are the read-only source node id, refreshed on each PHY register 0 transfer while clk_en is high.
// - Video bits 23:16 report the data block size that follows the stream type.
// - Video bits 15:14 hold the read-only fraction number with its four encodings.
// - Video bits 13:11 reflect the read-only quadlet padding count, reset zero.
// - Video bit 10 holds the source packet header flag sent in the CIP header.
// - Video bits 7:0 expose the read-only data block continuity counter.
// - The header flag is writable unless the new-cell header option is active.
`timescale 1ns/100ps
module tx_header_quadlet1_regs
    import txh1_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [4*NUM_BUF-1:0] stream_type,
    input wire logic [NUM_BUF-1:0] new_cell_header_option,
    input wire logic phy_reg0_valid,
    input wire logic [4:0] phy_node_id,
    input wire logic tx_pkt_done,
    input wire logic [2:0] tx_pkt_buf,
    input wire logic [7:0] tx_pkt_blocks,
    input wire logic [1:0] tx_pkt_fn,
    input wire logic [2:0] tx_pkt_qpc,
    input wire logic tx_pkt_sph,
    input wire logic hdr_req,
    input wire logic [2:0] hdr_buf,
    output logic [31:0] hdr_quadlet,
    output logic hdr_valid
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    bus_state_type state_r, state_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic hit_r, hit_nxt;
    logic we_r, we_nxt;
    logic ack_nxt;
    logic [31:0] dat_nxt;
    logic [2:0] adr_idx;
    logic adr_hit;
    logic bus_req;
    logic sw_wr;
    logic mem_we;
    logic [31:0] mem_rdata_a, mem_rdata_b;
    logic [4:0] src_id_r, src_id_nxt;
    logic [7:0] dbs_r [NUM_BUF];
    logic [7:0] dbs_nxt [NUM_BUF];
    logic [1:0] fn_r [NUM_BUF];
    logic [1:0] fn_nxt [NUM_BUF];
    logic [2:0] qpc_r [NUM_BUF];
    logic [2:0] qpc_nxt [NUM_BUF];
    logic sph_r [NUM_BUF];
    logic sph_nxt [NUM_BUF];
    logic [7:0] dbc_r [NUM_BUF];
    logic [7:0] dbc_nxt [NUM_BUF];
    logic hdr_pend_r, hdr_pend_nxt;
    logic [2:0] hdr_buf_r, hdr_buf_nxt;
    logic [31:0] hdr_nxt;
    logic hdr_valid_nxt;

    function automatic logic [3:0] st_of(input logic [2:0] idx);
        return stream_type[{idx, 2'b00} +: 4];
    endfunction

    // Video layout is built from live fields; reserved bits stay zero
    function automatic logic [31:0] quadlet_of(input logic [2:0] idx, input logic [31:0] stored);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (is_video(st_of(idx))) begin
            w[SRC_ID_LSB +: 5] = src_id_r;
            w[DBS_LSB +: 8] = dbs_r[idx];
            w[FN_LSB +: 2] = fn_r[idx];
            w[QPC_LSB +: 3] = qpc_r[idx];
            w[SPH_BIT] = sph_r[idx];
            w[DBC_LSB +: 8] = dbc_r[idx];
        end else begin
            // Types outside 1 and 4..10 fall back to the stored word
            w = stored;
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    always_comb begin
        adr_hit = 1'b0;
        adr_idx = 3'h0;
        for (int i = 0; i < NUM_BUF; i++) begin
            if (wb_adr_i[ADR_W-1:2] == BUF_OFFSET[i][ADR_W-1:2]) begin
                adr_hit = 1'b1;
                adr_idx = 3'(i);
            end
        end
    end

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign sw_wr = (state_r == BUS_IDLE) && bus_req && wb_we_i && adr_hit;
    // Writes to a video buffer never reach the store, so read-only fields stay intact
    assign mem_we = sw_wr && !is_video(st_of(adr_idx));

    txh1_store u_store (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .wr_en(mem_we),
        .wr_addr(adr_idx),
        .wr_be(wb_sel_i),
        .wr_data(wb_dat_i),
        .rd_addr_a(adr_idx),
        .rd_data_a(mem_rdata_a),
        .rd_addr_b(hdr_buf),
        .rd_data_b(mem_rdata_b)
    );

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        hit_nxt = hit_r;
        we_nxt = we_r;
        ack_nxt = 1'b0;
        dat_nxt = wb_dat_o;
        unique case (state_r)
            BUS_IDLE: begin
                if (bus_req) begin
                    idx_nxt = adr_idx;
                    hit_nxt = adr_hit;
                    we_nxt = wb_we_i;
                    state_nxt = BUS_FETCH;
                end
            end
            BUS_FETCH: begin
                // Unmapped reads answer with zero rather than stalling the master
                ack_nxt = 1'b1;
                dat_nxt = 32'h0000_0000;
                if (hit_r && !we_r) begin
                    dat_nxt = quadlet_of(idx_r, mem_rdata_a);
                end
                state_nxt = BUS_RESP;
            end
            BUS_RESP: begin
                state_nxt = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= BUS_IDLE;
            idx_r <= 3'h0;
            hit_r <= 1'b0;
            we_r <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (clk_en) begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            hit_r <= hit_nxt;
            we_r <= we_nxt;
            wb_ack_o <= ack_nxt;
            wb_dat_o <= dat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Source node id
    // ------------------------------------------------------------
    always_comb begin
        src_id_nxt = src_id_r;
        if (phy_reg0_valid) begin
            src_id_nxt = phy_node_id;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            src_id_r <= SRC_ID_RST;
        end else if (clk_en) begin
            src_id_r <= src_id_nxt;
        end
    end

    // ------------------------------------------------------------
    // Per-buffer video fields
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_BUF; g++) begin : gen_buf
        logic [3:0] st;
        logic pkt_here;
        logic wr_here;
        assign st = stream_type[4*g +: 4];
        assign pkt_here = tx_pkt_done && (tx_pkt_buf == 3'(g)) && is_video(st);
        assign wr_here = sw_wr && (adr_idx == 3'(g)) && is_video(st);

        always_comb begin
            dbs_nxt[g] = dbs_r[g];
            fn_nxt[g] = fn_r[g];
            qpc_nxt[g] = qpc_r[g];
            sph_nxt[g] = sph_r[g];
            dbc_nxt[g] = dbc_r[g];
            if (is_video(st)) begin
                dbs_nxt[g] = dbs_for(st);
            end
            if (pkt_here) begin
                dbc_nxt[g] = dbc_r[g] + tx_pkt_blocks;
                fn_nxt[g] = tx_pkt_fn;
                qpc_nxt[g] = tx_pkt_qpc;
                if (new_cell_header_option[g]) begin
                    sph_nxt[g] = tx_pkt_sph;
                end
            end
            // Software and hardware own the flag in turn, so they never collide
            if (wr_here && wb_sel_i[SPH_LANE] && !new_cell_header_option[g]) begin
                sph_nxt[g] = wb_dat_i[SPH_BIT];
            end
        end

        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                dbs_r[g] <= (g == 0) ? DBS_RST_BUF0 : DBS_RST_OTHER;
                fn_r[g] <= (g == 0) ? FN_RST_BUF0 : FN_RST_OTHER;
                sph_r[g] <= (g == 0) ? SPH_RST_BUF0 : SPH_RST_OTHER;
                qpc_r[g] <= QPC_RST;
                dbc_r[g] <= DBC_RST;
            end else if (clk_en) begin
                dbs_r[g] <= dbs_nxt[g];
                fn_r[g] <= fn_nxt[g];
                sph_r[g] <= sph_nxt[g];
                qpc_r[g] <= qpc_nxt[g];
                dbc_r[g] <= dbc_nxt[g];
            end
        end
    end

    // ------------------------------------------------------------
    // Header port toward packet assembly
    // ------------------------------------------------------------
    always_comb begin
        hdr_pend_nxt = hdr_req;
        hdr_buf_nxt = hdr_req ? hdr_buf : hdr_buf_r;
        hdr_valid_nxt = hdr_pend_r;
        hdr_nxt = hdr_quadlet;
        if (hdr_pend_r) begin
            hdr_nxt = quadlet_of(hdr_buf_r, mem_rdata_b);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hdr_pend_r <= 1'b0;
            hdr_buf_r <= 3'h0;
            hdr_valid <= 1'b0;
            hdr_quadlet <= 32'h0000_0000;
        end else if (clk_en) begin
            hdr_pend_r <= hdr_pend_nxt;
            hdr_buf_r <= hdr_buf_nxt;
            hdr_valid <= hdr_valid_nxt;
            hdr_quadlet <= hdr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    async_read_a: assert property (
        (clk_en && state_r == BUS_FETCH && hit_r && !we_r && st_of(idx_r) == ST_ASYNC)
        |=> (wb_dat_o == $past(mem_rdata_a)))
        else $error("async read data differs from store");

    video_node_a: assert property (
        (clk_en && state_r == BUS_FETCH && hit_r && !we_r && is_video(st_of(idx_r)))
        |=> (wb_dat_o[SRC_ID_LSB +: 5] == $past(src_id_r)))
        else $error("video read lacks source id");

    // Master still holds the address one cycle on, so the store reads the new word back
    async_write_a: assert property (
        (sw_wr && clk_en && st_of(adr_idx) == ST_ASYNC && wb_sel_i[3:2] == 2'b11) ##1 clk_en
        |=> (mem_rdata_a[31:16] == $past(wb_dat_i[31:16], 2)))
        else $error("async write not stored");

    hdr_async_a: assert property (
        (hdr_req && clk_en && st_of(hdr_buf) == ST_ASYNC) ##1 clk_en
        |=> (hdr_valid && hdr_quadlet == $past(mem_rdata_b)))
        else $error("async header quadlet wrong");

    reserved_zero_a: assert property (
        (wb_ack_o && is_video(st_of(idx_r)) && hit_r)
        |-> (wb_dat_o[31:29] == 3'h0 && wb_dat_o[9:8] == 2'h0))
        else $error("reserved bits not zero");

    node_refresh_a: assert property (
        (phy_reg0_valid && clk_en) |=> (src_id_r == $past(phy_node_id)))
        else $error("source id not refreshed");

    dbs_follow_a: assert property (
        (clk_en && is_video(stream_type[3:0])) |=> (dbs_r[0] == dbs_for($past(stream_type[3:0]))))
        else $error("block size does not follow stream type");

    reset_defaults_a: assert property (
        $fell(rst) |-> (dbs_r[0] == DBS_RST_BUF0 && fn_r[0] == FN_RST_BUF0 && sph_r[0]))
        else $error("buffer 0 reset defaults wrong");

    sph_locked_a: assert property (
        (clk_en && new_cell_header_option[0] && !(tx_pkt_done && tx_pkt_buf == 3'h0))
        |=> $stable(sph_r[0]))
        else $error("header flag changed while locked");

    dbc_step_a: assert property (
        (clk_en && tx_pkt_done && tx_pkt_buf == 3'h0 && is_video(stream_type[3:0]))
        |=> (dbc_r[0] == 8'($past(dbc_r[0]) + $past(tx_pkt_blocks))))
        else $error("continuity counter step wrong");

    padding_capture_a: assert property (
        (clk_en && tx_pkt_done && tx_pkt_buf == 3'h0 && is_video(stream_type[3:0]))
        |=> (qpc_r[0] == $past(tx_pkt_qpc) && fn_r[0] == $past(tx_pkt_fn)))
        else $error("padding or fraction not captured");

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    read_cov: cover property (wb_ack_o && hit_r && !we_r);
    write_cov: cover property (sw_wr && is_video(st_of(adr_idx)));
    pkt_cov: cover property (tx_pkt_done && clk_en);
    hdr_cov: cover property (hdr_valid);
    lock_cov: cover property (clk_en && new_cell_header_option[0] && tx_pkt_done);
endmodule

// ==== src/txh1_pkg.sv ====
// Constants, types and helpers for the transmit header quadlet 1 bank
package txh1_pkg;
    // ------------------------------------------------------------
    // Map
    // ------------------------------------------------------------
    localparam int NUM_BUF = 8;
    localparam int ADR_W = 12;
    localparam logic [ADR_W-1:0] BUF_OFFSET [NUM_BUF] = '{
        12'h258, 12'h270, 12'h288, 12'h2A0, 12'h2B8, 12'h2D0, 12'h2E8, 12'h300};
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int DEST_ID_LSB = 16;
    localparam int DEST_OFF_LSB = 0;
    localparam int SRC_ID_LSB = 24;
    localparam int DBS_LSB = 16;
    localparam int FN_LSB = 14;
    localparam int QPC_LSB = 11;
    localparam int SPH_BIT = 10;
    localparam int DBC_LSB = 0;
    localparam int SPH_LANE = 1;
    // ------------------------------------------------------------
    // Stream types and block sizes
    // ------------------------------------------------------------
    localparam logic [3:0] ST_ASYNC = 4'h1;
    localparam logic [3:0] ST_VIDEO_MIN = 4'h4;
    localparam logic [3:0] ST_VIDEO_MAX = 4'hA;
    localparam logic [3:0] ST_SAT_A = 4'h4;
    localparam logic [3:0] ST_SAT_B = 4'h5;
    localparam logic [3:0] ST_DVB = 4'h6;
    localparam logic [3:0] ST_PAL_SD = 4'h7;
    localparam logic [3:0] ST_PAL_HD = 4'h8;
    localparam logic [3:0] ST_NTSC_SD = 4'h9;
    localparam logic [3:0] ST_NTSC_HD = 4'hA;
    localparam logic [7:0] DBS_DVB = 8'h06;
    localparam logic [7:0] DBS_SAT = 8'h09;
    localparam logic [7:0] DBS_SD = 8'h78;
    localparam logic [7:0] DBS_HD = 8'hF0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DBS_RST_BUF0 = 8'h06;
    localparam logic [7:0] DBS_RST_OTHER = 8'h00;
    localparam logic [1:0] FN_RST_BUF0 = 2'h3;
    localparam logic [1:0] FN_RST_OTHER = 2'h0;
    localparam logic SPH_RST_BUF0 = 1'b1;
    localparam logic SPH_RST_OTHER = 1'b0;
    localparam logic [2:0] QPC_RST = 3'h0;
    localparam logic [7:0] DBC_RST = 8'h00;
    localparam logic [4:0] SRC_ID_RST = 5'h00;
    localparam logic [31:0] STORE_RST = 32'h0000_0000;

    typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_RESP} bus_state_type;

    function automatic logic is_video(input logic [3:0] st);
        return (st >= ST_VIDEO_MIN) && (st <= ST_VIDEO_MAX);
    endfunction

    function automatic logic [7:0] dbs_for(input logic [3:0] st);
        logic [7:0] v;
        v = DBS_RST_OTHER;
        if (st == ST_SAT_A || st == ST_SAT_B) v = DBS_SAT;
        if (st == ST_DVB) v = DBS_DVB;
        if (st == ST_PAL_SD || st == ST_NTSC_SD) v = DBS_SD;
        if (st == ST_PAL_HD || st == ST_NTSC_HD) v = DBS_HD;
        return v;
    endfunction
endpackage

// ==== src/txh1_store.sv ====
// Word store for the asynchronous layout, one write and two registered read ports
`timescale 1ns/100ps
module txh1_store
    import txh1_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [2:0] wr_addr,
    input wire logic [3:0] wr_be,
    input wire logic [31:0] wr_data,
    input wire logic [2:0] rd_addr_a,
    output logic [31:0] rd_data_a,
    input wire logic [2:0] rd_addr_b,
    output logic [31:0] rd_data_b
);
    logic [31:0] mem_r [NUM_BUF];

    // Reset clears every word, so both async fields start at zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_BUF; i++) begin
                mem_r[i] <= STORE_RST;
            end
            rd_data_a <= STORE_RST;
            rd_data_b <= STORE_RST;
        end else if (clk_en) begin
            for (int b = 0; b < 4; b++) begin
                if (wr_en && wr_be[b]) begin
                    mem_r[wr_addr][8*b +: 8] <= wr_data[8*b +: 8];
                end
            end
            rd_data_a <= mem_r[rd_addr_a];
            rd_data_b <= mem_r[rd_addr_b];
        end
    end
endmodule
